// file: src/mss_pkg.sv
package mss_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the APB bus)
   // ----------------------------------------------------------------
   localparam int APB_AW = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_INSTR = 12'h004;
   localparam logic [11:0] OFS_ACC = 12'h008;
   localparam logic [11:0] OFS_BANK = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_PROD = 12'h014;
   localparam logic [11:0] OFS_INDEX = 12'h018;
   localparam logic [11:0] OFS_WDOG = 12'h01C;
   localparam logic [11:0] OFS_FILE = 12'h100;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_WDOG_BIT = 1;
   localparam int ST_C_BIT = 0;
   localparam int ST_N_BIT = 4;
   localparam int ST_TO_BIT = 5;
   localparam int ST_PD_BIT = 6;
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_SLEEP_BIT = 8;
   localparam int OP_D_BIT = 9;
   localparam int OP_A_BIT = 8;
   localparam int BANK_W = 4;

   // ----------------------------------------------------------------
   // Opcodes and addressing constants
   // ----------------------------------------------------------------
   localparam logic [6:0] OPC_MUL_FILE = 7'h01;
   localparam logic [5:0] OPC_SUB_BORROW = 6'h15;
   localparam logic [5:0] OPC_SUB_FILE = 6'h17;
   localparam logic [7:0] OPC_SUB_LIT = 8'h08;
   localparam logic [15:0] OPC_SLEEP = 16'h0003;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic TO_RESET = 1'b1;
   localparam logic PD_RESET = 1'b1;
   localparam logic [15:0] INSTR_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } mss_flags_t;

   typedef struct packed {
      logic [7:0] res;
      mss_flags_t flags;
   } mss_sub_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_DECODE = 3'b001,
      PH_READ = 3'b010,
      PH_PROCESS = 3'b011,
      PH_WRITE = 3'b100
   } mss_phase_t;

   typedef enum logic [2:0] {
      CL_NOP = 3'b000,
      CL_MUL = 3'b001,
      CL_SUBB = 3'b010,
      CL_SUBL = 3'b011,
      CL_SUBF = 3'b100,
      CL_SLEEP = 3'b101
   } mss_class_t;

endpackage

// file: src/mss_sub8.sv
`timescale 1ns/1ps
module mss_sub8
   import mss_pkg::*;
(
   // Operands
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   input wire logic carry_in,
   // Result
   output mss_sub_t out
);

   logic [8:0] sum9;
   logic [4:0] sum5;

   // Add the inverted subtrahend; carry in high means no borrow
   always_comb begin
      sum9 = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
      sum5 = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
      out.res = sum9[7:0];
      out.flags.c = sum9[8];
      out.flags.dc = sum5[4];
      out.flags.z = (sum9[7:0] == 8'h00);
      out.flags.n = sum9[7];
      out.flags.ov = (minuend[7] != subtrahend[7]) && (sum9[7] != minuend[7]);
   end

endmodule

// file: src/mss_exec.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - The file multiply forms the unsigned accumulator-times-file product, high byte to product_high, low to product_low.
// RL2 - The file multiply leaves accumulator, source register and every status flag untouched.
// RL3 - The file multiply is decoded as 0000 001a with an 8-bit file address, bit 8 being the access-bank bit.
// RL4 - With the a bit clear the access bank is used, with it set bank_select picks the register bank.
// RL5 - With a clear, extended set enabled and address at most 95, the operand is addressed indexed from a base.
// RL6 - A destination bit of 0 sends a subtract result to the accumulator, 1 sends it back to the file register.
// RL7 - Subtract with borrow computes accumulator minus file minus inverted carry and updates N, OV, C, DC and Z.
// RL8 - Literal subtract computes literal minus accumulator into the accumulator and updates all five flags.
// RL9 - File subtract computes file minus accumulator to the selected destination and updates all five flags.
// RL10 - The file subtract is decoded from upper bits 010111 with d at bit 9, a at bit 8 and the address low.
// RL11 - Sleep clears the watchdog and its postscaler, sets the expiry flag, clears the power-down flag and stops the clock.
// RL12 - Every instruction is one word executed in four phases: decode, read, process, write.
// RL13 - For subtracts carry means no borrow, zero means an all-zero result and negative copies the result MSB.
// RL14 - A wake-up caused by watchdog expiry clears the expiry flag.
module mss_exec
   import mss_pkg::*;
#(
   parameter int FILE_DEPTH = 64,
   parameter int WDOG_POSTSCALE = 16,
   parameter int WDOG_LIMIT = 256
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wake-up request from outside, asynchronous
   input wire logic wake_in,
   // Core clock gate, high while asleep
   output logic osc_stop
);

   localparam int IDX_W = $clog2(FILE_DEPTH);
   localparam int PS_W = $clog2(WDOG_POSTSCALE);
   localparam int WD_W = $clog2(WDOG_LIMIT);
   localparam logic [PS_W-1:0] PS_LAST = PS_W'(WDOG_POSTSCALE - 1);
   localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDOG_LIMIT - 1);
   localparam logic [APB_AW-1:0] FILE_END = OFS_FILE + APB_AW'(FILE_DEPTH * 4);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (FILE_DEPTH < 16 || FILE_DEPTH > 256 || (FILE_DEPTH & (FILE_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FILE_DEPTH must be a power of two from 16 to 256");
   end
   if (WDOG_POSTSCALE < 2 || WDOG_LIMIT < 2) begin : g_bad_wdog
      $error("Watchdog postscale and limit must be at least 2");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] file_mem [FILE_DEPTH];
   logic [7:0] acc_reg, index_reg, prod_hi_reg, prod_lo_reg, opnd_reg, res_reg;
   logic [BANK_W-1:0] bank_reg;
   logic ext_en_reg, wdog_en_reg, expiry_reg, slept_reg, asleep_reg, dest_reg;
   mss_flags_t flags_reg, new_flags_reg;
   logic [15:0] instr_reg, prod_reg;
   mss_phase_t phase_reg;
   mss_class_t class_reg;
   logic [IDX_W-1:0] ea_reg;
   logic [PS_W-1:0] ps_reg;
   logic [WD_W-1:0] wdog_reg;
   logic [2:0] wake_sync_reg;
   logic wake_lvl_reg, pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;

   logic busy, apb_access, apb_commit, wr_ok, addr_is_file, wr_locked;
   logic [11:0] full_addr;
   logic [IDX_W-1:0] apb_idx;
   logic [7:0] faddr, sub_a, sub_b;
   logic sub_cin, wdog_tick, wdog_expire, exec_start, in_write;
   mss_sub_t sub_out;
   mss_class_t dec_class;

   assign busy = (phase_reg != PH_IDLE);
   assign in_write = (phase_reg == PH_WRITE);
   assign apb_access = psel & penable & ~pready_reg;
   assign apb_commit = psel & penable & pready_reg;
   assign wr_ok = apb_commit & pwrite & ~pslverr_reg;
   assign addr_is_file = (paddr >= OFS_FILE) && (paddr < FILE_END) && (paddr[1:0] == 2'b00);
   assign apb_idx = IDX_W'((paddr - OFS_FILE) >> 2);
   assign exec_start = wr_ok & (paddr == OFS_INSTR);
   assign faddr = instr_reg[7:0];
   // Writes that would race the executing instruction are refused, as is a new instruction while asleep
   assign wr_locked = pwrite & ((busy & (addr_is_file | paddr == OFS_INSTR | paddr == OFS_ACC | paddr == OFS_BANK
      | paddr == OFS_STATUS | paddr == OFS_INDEX)) | (asleep_reg & paddr == OFS_INSTR));

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   always_comb begin
      if (instr_reg[15:9] == OPC_MUL_FILE) begin
         dec_class = CL_MUL; // [RL3]
      end else if (instr_reg[15:10] == OPC_SUB_BORROW) begin
         dec_class = CL_SUBB;
      end else if (instr_reg[15:10] == OPC_SUB_FILE) begin
         dec_class = CL_SUBF; // [RL10]
      end else if (instr_reg[15:8] == OPC_SUB_LIT) begin
         dec_class = CL_SUBL;
      end else if (instr_reg == OPC_SLEEP) begin
         dec_class = CL_SLEEP;
      end else begin
         dec_class = CL_NOP;
      end
   end

   // Effective file address from a bit, bank and extended mode
   always_comb begin
      if (!instr_reg[OP_A_BIT] && ext_en_reg && faddr < ACCESS_SPLIT) begin
         full_addr = {ACCESS_LOW_BANK, 8'(index_reg + faddr)}; // [RL5]
      end else if (!instr_reg[OP_A_BIT]) begin
         full_addr = {(faddr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, faddr}; // [RL4]
      end else begin
         full_addr = {bank_reg, faddr}; // [RL4]
      end
   end

   // ----------------------------------------------------------------
   // Subtract unit operand steering
   // ----------------------------------------------------------------
   always_comb begin
      sub_a = opnd_reg;
      sub_b = acc_reg;
      sub_cin = 1'b1;
      if (class_reg == CL_SUBB) begin
         sub_a = acc_reg; // [RL7]
         sub_b = opnd_reg;
         sub_cin = flags_reg.c;
      end
   end

   mss_sub8 u_sub (
      .minuend(sub_a),
      .subtrahend(sub_b),
      .carry_in(sub_cin),
      .out(sub_out)
   );

   // ----------------------------------------------------------------
   // Four-phase sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= PH_IDLE;
      end else begin
         case (phase_reg) // [RL12]
            PH_IDLE: begin
               if (exec_start) begin
                  phase_reg <= PH_DECODE;
               end
            end
            PH_DECODE: phase_reg <= PH_READ;
            PH_READ: phase_reg <= PH_PROCESS;
            PH_PROCESS: phase_reg <= PH_WRITE;
            PH_WRITE: phase_reg <= PH_IDLE;
            default: phase_reg <= PH_IDLE;
         endcase
      end
   end

   // Datapath pipeline: decode, operand fetch, compute
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         class_reg <= CL_NOP;
         dest_reg <= 1'b0;
         ea_reg <= '0;
         opnd_reg <= 8'h00;
         res_reg <= 8'h00;
         prod_reg <= 16'h0000;
         new_flags_reg <= '0;
      end else begin
         if (phase_reg == PH_DECODE) begin
            class_reg <= dec_class;
            dest_reg <= instr_reg[OP_D_BIT];
            ea_reg <= full_addr[IDX_W-1:0];
         end
         if (phase_reg == PH_READ) begin
            opnd_reg <= (class_reg == CL_SUBL) ? faddr : file_mem[ea_reg]; // [RL8]
         end
         if (phase_reg == PH_PROCESS) begin
            prod_reg <= {8'h00, acc_reg} * {8'h00, opnd_reg}; // [RL1]
            res_reg <= sub_out.res; // [RL9]
            new_flags_reg <= sub_out.flags; // [RL13]
         end
      end
   end

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   // Accumulator: execution write beats software, which is refused while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= 8'h00;
      end else if (in_write && (class_reg == CL_SUBL || ((class_reg == CL_SUBB || class_reg == CL_SUBF) && !dest_reg))) begin
         acc_reg <= res_reg; // [RL6] [RL8]
      end else if (wr_ok && paddr == OFS_ACC) begin
         acc_reg <= pwdata[7:0];
      end
   end

   // File storage; multiply never writes here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_mem[i] <= 8'h00;
         end
      end else if (in_write && (class_reg == CL_SUBB || class_reg == CL_SUBF) && dest_reg) begin
         file_mem[ea_reg] <= res_reg; // [RL6] [RL2]
      end else if (wr_ok && addr_is_file) begin
         file_mem[apb_idx] <= pwdata[7:0];
      end
   end

   // Product pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prod_hi_reg <= 8'h00;
         prod_lo_reg <= 8'h00;
      end else if (in_write && class_reg == CL_MUL) begin
         prod_hi_reg <= prod_reg[15:8]; // [RL1]
         prod_lo_reg <= prod_reg[7:0];
      end
   end

   // Arithmetic flags; the multiply and sleep leave them alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= '0;
      end else if (in_write && (class_reg == CL_SUBB || class_reg == CL_SUBL || class_reg == CL_SUBF)) begin
         flags_reg <= new_flags_reg; // [RL7] [RL9] [RL2]
      end else if (wr_ok && paddr == OFS_STATUS) begin
         flags_reg <= pwdata[ST_N_BIT:ST_C_BIT];
      end
   end

   // Control, bank, index base and instruction word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_en_reg <= 1'b0;
         wdog_en_reg <= 1'b0;
         bank_reg <= '0;
         index_reg <= 8'h00;
         instr_reg <= INSTR_RESET;
      end else if (wr_ok) begin
         if (paddr == OFS_CTRL) begin
            ext_en_reg <= pwdata[CTRL_EXT_BIT];
            wdog_en_reg <= pwdata[CTRL_WDOG_BIT];
         end
         if (paddr == OFS_BANK) begin
            bank_reg <= pwdata[BANK_W-1:0];
         end
         if (paddr == OFS_INDEX) begin
            index_reg <= pwdata[7:0];
         end
         if (paddr == OFS_INSTR) begin
            instr_reg <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Watchdog and sleep
   // ----------------------------------------------------------------
   assign wdog_tick = wdog_en_reg && (ps_reg == PS_LAST);
   assign wdog_expire = wdog_tick && (wdog_reg == WD_LAST);

   // Counter keeps running while asleep, it is the only timed wake source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_reg <= '0;
         wdog_reg <= '0;
      end else if (in_write && class_reg == CL_SLEEP) begin
         ps_reg <= '0; // [RL11]
         wdog_reg <= '0;
      end else if (wdog_en_reg) begin
         ps_reg <= wdog_tick ? '0 : ps_reg + 1'b1;
         if (wdog_tick) begin
            wdog_reg <= wdog_expire ? '0 : wdog_reg + 1'b1;
         end
      end
   end

   // Three-stage sync; level changes only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_sync_reg <= 3'b000;
         wake_lvl_reg <= 1'b0;
      end else begin
         wake_sync_reg <= {wake_sync_reg[1:0], wake_in};
         if (wake_sync_reg[1] == wake_sync_reg[2]) begin
            wake_lvl_reg <= wake_sync_reg[2];
         end
      end
   end

   // Sleep state and power flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asleep_reg <= 1'b0;
         expiry_reg <= TO_RESET;
         slept_reg <= PD_RESET;
      end else if (in_write && class_reg == CL_SLEEP) begin
         asleep_reg <= 1'b1; // [RL11]
         expiry_reg <= 1'b1;
         slept_reg <= 1'b0;
      end else if (wdog_expire) begin
         asleep_reg <= 1'b0;
         expiry_reg <= 1'b0; // [RL14]
      end else if (asleep_reg && wake_lvl_reg) begin
         asleep_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: answer in the second access cycle
   // ----------------------------------------------------------------
   // Read data and error are registered, so they stand until the next answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= apb_access;
         if (apb_access) begin
            pslverr_reg <= wr_locked;
            prdata_reg <= 32'h0000_0000;
            if (addr_is_file) begin
               prdata_reg <= {24'h00_0000, file_mem[apb_idx]};
            end else begin
               case (paddr)
                  OFS_CTRL: prdata_reg <= {30'h0000_0000, wdog_en_reg, ext_en_reg};
                  OFS_INSTR: prdata_reg <= {16'h0000, instr_reg};
                  OFS_ACC: prdata_reg <= {24'h00_0000, acc_reg};
                  OFS_BANK: prdata_reg <= {28'h000_0000, bank_reg};
                  OFS_STATUS: prdata_reg <= {23'h00_0000, asleep_reg, busy, slept_reg, expiry_reg, flags_reg};
                  OFS_PROD: prdata_reg <= {16'h0000, prod_hi_reg, prod_lo_reg};
                  OFS_INDEX: prdata_reg <= {24'h00_0000, index_reg};
                  OFS_WDOG: prdata_reg <= 32'(wdog_reg);
                  default: pslverr_reg <= 1'b1;
               endcase
            end
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign osc_stop = asleep_reg; // [RL11]

endmodule

// file: verification/mss_exec_properties.sv
`timescale 1ns/1ps
// ----
// Port-level checks on the executor
// ----
module mss_exec_properties
   import mss_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Sleep
   input wire logic wake_in,
   input wire logic osc_stop
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic xfer_done;
   logic [2:0] age_reg;
   logic sleep_op_reg;
   // Committed transfer
   assign xfer_done = psel && penable && pready;
   // Edges since the last accepted instruction; saturates so long idle spans stay cheap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_reg <= 3'h0;
         sleep_op_reg <= 1'b0;
      end else if (xfer_done && pwrite && !pslverr && paddr == OFS_INSTR) begin
         age_reg <= 3'h1;
         sleep_op_reg <= (pwdata[15:0] == OPC_SLEEP);
      end else if (age_reg != 3'h0 && age_reg != 3'h7) begin
         age_reg <= age_reg + 3'h1;
      end
   end
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_access_len: assert property (psel && penable && !pready && !$past(penable) |=> pready)
      else $error("access phase not two cycles");
   a_misalign_err: assert property (xfer_done && paddr[1:0] != 2'b00 |-> pslverr) else $error("unaligned accepted");
   a_busy_refuse: assert property (xfer_done && pwrite && paddr == OFS_ACC && age_reg inside {[1:4]} |-> pslverr)
      else $error("write accepted while busy");
   a_busy_set: assert property (xfer_done && !pwrite && paddr == OFS_STATUS && age_reg inside {[3:4]}
      |-> prdata[ST_BUSY_BIT]) else $error("busy missing during execution");
   a_busy_clear: assert property (xfer_done && !pwrite && paddr == OFS_STATUS && !osc_stop
      && (age_reg == 3'h0 || age_reg == 3'h7) |-> !prdata[ST_BUSY_BIT]) else $error("busy after four phases");
   a_sleep_entry: assert property (xfer_done && pwrite && !pslverr && paddr == OFS_INSTR
      && pwdata[15:0] == OPC_SLEEP |-> ##[4:6] osc_stop) else $error("sleep not entered");
   a_sleep_cause: assert property ($rose(osc_stop) |-> sleep_op_reg && age_reg inside {[4:6]})
      else $error("clock stopped without sleep");
   a_sleep_status: assert property (xfer_done && !pwrite && paddr == OFS_STATUS && osc_stop && $past(osc_stop)
      && $past(osc_stop, 2) |-> !prdata[ST_PD_BIT] && prdata[ST_SLEEP_BIT]) else $error("sleep status wrong");
   a_asleep_refuse: assert property (xfer_done && pwrite && paddr == OFS_INSTR && osc_stop && $past(osc_stop)
      |-> pslverr) else $error("instruction accepted asleep");
endmodule

bind mss_exec mss_exec_properties i_mss_exec_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wake_in(wake_in), .osc_stop(osc_stop)
);

// file: verification/mss_exec_bench.sv
`timescale 1ns/1ps
module mss_exec_bench
   import mss_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic wake_in = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic osc_stop;
   logic [31:0] rdv;
   logic errv;
   logic [15:0] lf = 16'h001B;
   int checked = 0;
   int bad_count = 0;

   // 200 MHz
   always #2.5 pclk = ~pclk;

   // Short watchdog counts keep the wake-up test brief
   mss_exec #(.FILE_DEPTH(16), .WDOG_POSTSCALE(2), .WDOG_LIMIT(4)) i_mss_exec (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wake_in(wake_in), .osc_stop(osc_stop)
   );

   // ----
   // Helpers
   // ----
   function automatic logic [7:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction

   // Flags {N, OV, Z, DC, C} over the 8-bit difference m - s - !ci
   function automatic logic [12:0] sub_ref(input logic [7:0] m, input logic [7:0] s, input logic ci);
      logic [8:0] r;
      logic [4:0] h;
      r = {1'b0, m} + {1'b0, ~s} + {8'h0, ci};
      h = {1'b0, m[3:0]} + {1'b0, ~s[3:0]} + {4'h0, ci};
      return {r[7], (m[7] != s[7]) && (r[7] != m[7]), r[7:0] == 8'h00, h[4], r[8], r[7:0]};
   endfunction

   function automatic logic [11:0] fa(input logic [3:0] i);
      return OFS_FILE + {6'h0, i, 2'b00};
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits for pready however long, only the watchdog ends a dead wait
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdv, e);
   endtask

   // Four phases, then two more edges before the checks
   task run(input logic [15:0] op);
      xfer(1'b1, OFS_INSTR, {16'h0000, op});
      chk({31'h0, errv}, 32'h0000_0000);
      repeat (6) @(posedge pclk);
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Whole run is near 850 cycles; 20000 leaves ample margin
   initial begin
      #100000;
      bad_count++;
      tally_and_finish;
   end

   // ----
   // Main sequence
   // ----
   initial begin
      logic [7:0] a;
      logic [7:0] f;
      logic [7:0] k;
      logic [4:0] st;
      logic [12:0] e;
      logic [15:0] op;
      logic dd;
      logic wa;
      int n;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rc(OFS_STATUS, 32'h0000_0060);
      rc(OFS_PROD, 32'h0000_0000);
      $display("test reset done");
      for (int t = 0; t < 6; t++) begin
         a = (t == 0) ? 8'hFF : (t == 1) ? 8'hC4 : (t == 2) ? 8'h00 : rnd();
         f = (t == 0) ? 8'hFF : (t == 1) ? 8'hB5 : rnd();
         k = rnd();
         xfer(1'b1, OFS_ACC, {24'h0, a});
         xfer(1'b1, fa(k[3:0]), {24'h0, f});
         xfer(1'b1, OFS_STATUS, {27'h0, k[7:3]});
         run({OPC_MUL_FILE, 1'b1, k});
         rc(OFS_PROD, {16'h0000, 16'(a) * 16'(f)});
         rc(OFS_ACC, {24'h0, a});
         rc(fa(k[3:0]), {24'h0, f});
         rc(OFS_STATUS, {23'h0, 4'b0011, k[7:3]});
      end
      $display("test multiply done");
      for (int t = 0; t < 12; t++) begin
         a = (t < 3) ? 8'h02 : rnd();
         f = (t < 3) ? 8'h02 : rnd();
         k = rnd();
         st = (t < 3) ? 5'h01 : k[7:3];
         dd = 1'((t / 3) % 2);
         xfer(1'b1, OFS_ACC, {24'h0, a});
         xfer(1'b1, fa(k[3:0]), {24'h0, f});
         xfer(1'b1, OFS_STATUS, {27'h0, st});
         e = (t % 3 == 0) ? sub_ref(a, f, st[0]) : sub_ref(f, a, 1'b1);
         op = (t % 3 == 0) ? {OPC_SUB_BORROW, dd, 1'b1, k} : (t % 3 == 1) ? {OPC_SUB_LIT, f} : {OPC_SUB_FILE, dd, 1'b1, k};
         wa = !dd || (t % 3 == 1);
         run(op);
         rc(OFS_ACC, {24'h0, wa ? e[7:0] : a});
         rc(fa(k[3:0]), {24'h0, wa ? f : e[7:0]});
         rc(OFS_STATUS, {23'h0, 4'b0011, e[12:8]});
      end
      $display("test subtract done");
      xfer(1'b1, OFS_INDEX, 32'h0000_0005);
      xfer(1'b1, OFS_CTRL, 32'h0000_0001);
      xfer(1'b1, OFS_ACC, 32'h0000_0001);
      xfer(1'b1, fa(4'h7), 32'h0000_0030);
      xfer(1'b1, fa(4'h2), 32'h0000_0010);
      run({OPC_SUB_FILE, 1'b1, 1'b0, 8'h02});
      rc(fa(4'h7), 32'h0000_002F);
      xfer(1'b1, OFS_CTRL, 32'h0000_0000);
      run({OPC_SUB_FILE, 1'b1, 1'b0, 8'h02});
      rc(fa(4'h2), 32'h0000_000F);
      xfer(1'b1, OFS_CTRL, 32'h0000_0001);
      run({OPC_SUB_FILE, 1'b1, 1'b1, 8'h02});
      rc(fa(4'h2), 32'h0000_000E);
      run({OPC_SUB_FILE, 1'b1, 1'b0, 8'h62});
      rc(fa(4'h2), 32'h0000_000D);
      $display("test addressing done");
      xfer(1'b1, OFS_INSTR, {16'h0000, OPC_MUL_FILE, 1'b1, 8'h02});
      xfer(1'b1, OFS_ACC, 32'h0000_0055);
      chk({31'h0, errv}, 32'h0000_0001);
      repeat (6) @(posedge pclk);
      rc(OFS_ACC, 32'h0000_0001);
      run(16'hFFFF);
      rc(OFS_ACC, 32'h0000_0001);
      xfer(1'b1, OFS_INSTR, {16'h0000, OPC_MUL_FILE, 1'b1, 8'h02});
      xfer(1'b0, OFS_STATUS, 32'h0000_0000);
      chk({31'h0, rdv[ST_BUSY_BIT]}, 32'h0000_0001);
      repeat (6) @(posedge pclk);
      xfer(1'b0, 12'h002, 32'h0000_0000);
      chk({31'h0, errv}, 32'h0000_0001);
      xfer(1'b1, 12'h020, 32'h0000_0000);
      chk({31'h0, errv}, 32'h0000_0001);
      $display("test busy done");
      run(OPC_SLEEP);
      chk({31'h0, osc_stop}, 32'h0000_0001);
      xfer(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_01E0, 32'h0000_0120);
      xfer(1'b1, OFS_INSTR, {16'h0000, OPC_SUB_LIT, 8'h00});
      chk({31'h0, errv}, 32'h0000_0001);
      wake_in <= 1'b1;
      for (n = 0; n < 20 && osc_stop !== 1'b0; n++) @(posedge pclk);
      wake_in <= 1'b0;
      xfer(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_01E0, 32'h0000_0020);
      $display("test wake request done");
      xfer(1'b1, OFS_CTRL, 32'h0000_0002);
      run(OPC_SLEEP);
      chk({31'h0, osc_stop}, 32'h0000_0001);
      for (n = 0; n < 40 && osc_stop !== 1'b0; n++) @(posedge pclk);
      xfer(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_01E0, 32'h0000_0000);
      xfer(1'b1, OFS_CTRL, 32'h0000_0000);
      $display("test watchdog wake done");
      tally_and_finish;
   end
endmodule
